/* hdl/rsf_rail_status_regs.sv */
// rail power-good, power-fault and thermal status register bank
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - power good b is read only with five-volt on 5, aux one on 4, termination on 3, aux three on 0.
// - each power-good bit reads 1 while its rail is in regulation and 0 otherwise.
// - fault a sets bit 7 for aux two and bits 5..0 for step-down six..one losing regulation.
// - fault b sets bit 4 for aux one, bit 3 for termination and bit 0 for aux three.
// - writing 1 to a fault bit clears it and writing 0 leaves it unchanged.
// - the thermal register collects five sensors, each flagging when above the hot threshold.
// - thermal bits are die 4, termination 3, top-right 2, top-left 1, bottom-right 0.
// - writing 1 to a thermal bit clears it and a 0 means no hot condition seen.
// - the registers decode at b1, b2, b3 and b5, each eight bits wide.
// - all status bits, reserved ones too, read 0 after reset.
// - a fault causes shutdown only when its mask bit is 0.
module rsf_rail_status_regs
  import rsf_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // register access port from the serial protocol engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // analog comparators, asynchronous to clk
  input wire logic five_volt_linear_good,
  input wire logic aux_linear_one_good,
  input wire logic termination_reg_good,
  input wire logic aux_linear_three_good,
  input wire logic aux_linear_two_fault,
  input wire logic [5:0] step_down_fault,
  input wire logic aux_linear_one_fault,
  input wire logic termination_reg_fault,
  input wire logic aux_linear_three_fault,
  input wire logic [4:0] sensor_hot,
  // fault masks held in the mask registers elsewhere
  input wire logic [7:0] fault_mask_a,
  input wire logic [7:0] fault_mask_b,
  output logic shutdown_req
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // each comparator and sensor level owns one bit of the synchroniser
  // vector; the indices keep the packing below and the unpacking in step
  localparam int SYNC_W = 19;
  localparam int IX_GOOD_FIVE = 0;
  localparam int IX_GOOD_AUX_ONE = 1;
  localparam int IX_GOOD_TERM = 2;
  localparam int IX_GOOD_AUX_THREE = 3;
  localparam int IX_STEP_LSB = 4;
  localparam int IX_FAULT_AUX_TWO = 10;
  localparam int IX_FAULT_AUX_ONE = 11;
  localparam int IX_FAULT_TERM = 12;
  localparam int IX_FAULT_AUX_THREE = 13;
  localparam int IX_HOT_LSB = 14;

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_a_reg;
  logic [SYNC_W-1:0] sync_b_reg;
  assign raw_in = {sensor_hot, aux_linear_three_fault, termination_reg_fault,
                   aux_linear_one_fault, aux_linear_two_fault, step_down_fault,
                   aux_linear_three_good, termination_reg_good, aux_linear_one_good,
                   five_volt_linear_good};

  // the first stage may go metastable, so nothing but the second stage reads
  // it; the price is three cycles between a pin change and its flag
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_a_reg <= {SYNC_W{1'b0}};
      sync_b_reg <= {SYNC_W{1'b0}};
    end else begin
      sync_a_reg <= raw_in;
      sync_b_reg <= sync_a_reg;
    end
  end

  // ----------------------------------------------------------------
  // field mapping
  // ----------------------------------------------------------------
  logic [7:0] good_b_live;
  logic [7:0] fault_a_set;
  logic [7:0] fault_b_set;
  logic [7:0] hot_set;
  logic [RSF_FA_STEP_NUM-1:0] step_s;
  logic [RSF_HOT_NUM-1:0] hot_s;
  assign step_s = sync_b_reg[IX_STEP_LSB +: RSF_FA_STEP_NUM];
  assign hot_s = sync_b_reg[IX_HOT_LSB +: RSF_HOT_NUM];

  // reserved positions stay 0; good bits track the live level
  always_comb begin
    good_b_live = 8'h00;
    good_b_live[RSF_GB_FIVE_VOLT] = sync_b_reg[IX_GOOD_FIVE];
    good_b_live[RSF_GB_AUX_ONE] = sync_b_reg[IX_GOOD_AUX_ONE];
    good_b_live[RSF_GB_TERM] = sync_b_reg[IX_GOOD_TERM];
    good_b_live[RSF_GB_AUX_THREE] = sync_b_reg[IX_GOOD_AUX_THREE];
  end

  // the set vectors are live levels; the sticky bytes turn them into flags
  always_comb begin
    fault_a_set = 8'h00;
    fault_a_set[RSF_FA_STEP_LSB +: RSF_FA_STEP_NUM] = step_s;
    fault_a_set[RSF_FA_AUX_TWO] = sync_b_reg[IX_FAULT_AUX_TWO];
  end

  always_comb begin
    fault_b_set = 8'h00;
    fault_b_set[RSF_FB_AUX_ONE] = sync_b_reg[IX_FAULT_AUX_ONE];
    fault_b_set[RSF_FB_TERM] = sync_b_reg[IX_FAULT_TERM];
    fault_b_set[RSF_FB_AUX_THREE] = sync_b_reg[IX_FAULT_AUX_THREE];
  end

  // sensor_hot[4]=die, [3]=termination, [2]=top-right, [1]=top-left, [0]=bottom-right
  always_comb begin
    hot_set = 8'h00;
    hot_set[RSF_HOT_DIE] = hot_s[4];
    hot_set[RSF_HOT_TERM] = hot_s[3];
    hot_set[RSF_HOT_TOP_RIGHT] = hot_s[2];
    hot_set[RSF_HOT_TOP_LEFT] = hot_s[1];
    hot_set[RSF_HOT_BOT_RIGHT] = hot_s[0];
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire sel_good_b = (reg_addr == RSF_ADDR_GOOD_B);
  wire sel_fault_a = (reg_addr == RSF_ADDR_FAULT_A);
  wire sel_fault_b = (reg_addr == RSF_ADDR_FAULT_B);
  wire sel_hot = (reg_addr == RSF_ADDR_HOT);
  wire sel_any = sel_good_b | sel_fault_a | sel_fault_b | sel_hot;
  // a write to the read-only power-good byte still hits but changes nothing
  wire clr_fault_a = reg_wr & sel_fault_a;
  wire clr_fault_b = reg_wr & sel_fault_b;
  wire clr_hot = reg_wr & sel_hot;

  // ----------------------------------------------------------------
  // status registers
  // ----------------------------------------------------------------
  logic [7:0] good_b_reg;
  logic [7:0] fault_a_q;
  logic [7:0] fault_b_q;
  logic [7:0] hot_q;

  // power good is a plain copy of the live level, never sticky, so a rail
  // that drops out reads 0 from the next sample on
  always_ff @(posedge clk) begin
    if (srst) begin
      good_b_reg <= RSF_RESET_VAL;
    end else begin
      good_b_reg <= good_b_live & RSF_MASK_GOOD_B;
    end
  end

  rsf_sticky_byte #(.IMPL_MASK(RSF_MASK_FAULT_A)) u_fault_a (
    .clk(clk),
    .srst(srst),
    .set_in(fault_a_set),
    .clr_en(clr_fault_a),
    .clr_data(reg_wdata),
    .flags(fault_a_q)
  );
  rsf_sticky_byte #(.IMPL_MASK(RSF_MASK_FAULT_B)) u_fault_b (
    .clk(clk),
    .srst(srst),
    .set_in(fault_b_set),
    .clr_en(clr_fault_b),
    .clr_data(reg_wdata),
    .flags(fault_b_q)
  );
  rsf_sticky_byte #(.IMPL_MASK(RSF_MASK_HOT)) u_hot (
    .clk(clk),
    .srst(srst),
    .set_in(hot_set),
    .clr_en(clr_hot),
    .clr_data(reg_wdata),
    .flags(hot_q)
  );

  // ----------------------------------------------------------------
  // read port and shutdown
  // ----------------------------------------------------------------
  // no more than one select is high for any address, so the read path is a plain or
  // of gated bytes and an unmapped address falls out as 0
  function automatic logic [7:0] gate_byte(input logic sel, input logic [7:0] value);
    return sel ? value : 8'h00;
  endfunction

  // a rail asks for shutdown only while it is live and its mask bit is 0
  function automatic logic any_unmasked(input logic [7:0] live, input logic [7:0] mask);
    return |(live & ~mask);
  endfunction

  logic [7:0] rdata_mux;
  assign rdata_mux = gate_byte(sel_good_b, good_b_reg) | gate_byte(sel_fault_a, fault_a_q) |
                     gate_byte(sel_fault_b, fault_b_q) | gate_byte(sel_hot, hot_q);

  // live synchronised levels, not sticky flags: a masked rail is still
  // flagged in its register but never trips
  logic trip_a;
  logic trip_b;
  assign trip_a = any_unmasked(fault_a_set, fault_mask_a);
  assign trip_b = any_unmasked(fault_b_set, fault_mask_b);
  wire trip = trip_a | trip_b;

  // read data drops back to 0 between reads so a stale byte never looks like an answer
  logic [7:0] rdata_reg;
  logic hit_reg;
  logic shutdown_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
      shutdown_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd ? rdata_mux : 8'h00;
      hit_reg <= (reg_rd | reg_wr) & sel_any;
      shutdown_reg <= trip;
    end
  end
  assign reg_rdata = rdata_reg;
  assign reg_hit = hit_reg;
  assign shutdown_req = shutdown_reg;
endmodule // rsf_rail_status_regs
`default_nettype wire

/* include/rsf_pkg.sv */
// package: offsets, field positions and reset values of the rail status bank
`default_nettype none
package rsf_pkg;
  localparam logic [7:0] RSF_ADDR_GOOD_B = 8'hb1;
  localparam logic [7:0] RSF_ADDR_FAULT_A = 8'hb2;
  localparam logic [7:0] RSF_ADDR_FAULT_B = 8'hb3;
  localparam logic [7:0] RSF_ADDR_HOT = 8'hb5;
  localparam logic [7:0] RSF_RESET_VAL = 8'h00;
  // power good b fields
  localparam int RSF_GB_FIVE_VOLT = 5;
  localparam int RSF_GB_AUX_ONE = 4;
  localparam int RSF_GB_TERM = 3;
  localparam int RSF_GB_AUX_THREE = 0;
  // fault a fields; step-down regs one..six sit on bits 0..5
  localparam int RSF_FA_AUX_TWO = 7;
  localparam int RSF_FA_STEP_LSB = 0;
  localparam int RSF_FA_STEP_NUM = 6;
  // fault b fields
  localparam int RSF_FB_AUX_ONE = 4;
  localparam int RSF_FB_TERM = 3;
  localparam int RSF_FB_AUX_THREE = 0;
  // thermal fields
  localparam int RSF_HOT_DIE = 4;
  localparam int RSF_HOT_TERM = 3;
  localparam int RSF_HOT_TOP_RIGHT = 2;
  localparam int RSF_HOT_TOP_LEFT = 1;
  localparam int RSF_HOT_BOT_RIGHT = 0;
  localparam int RSF_HOT_NUM = 5;
  // implemented-bit masks
  localparam logic [7:0] RSF_MASK_FAULT_A = 8'hbf;
  localparam logic [7:0] RSF_MASK_FAULT_B = 8'h19;
  localparam logic [7:0] RSF_MASK_HOT = 8'h1f;
  localparam logic [7:0] RSF_MASK_GOOD_B = 8'h39;
endpackage
`default_nettype wire

/* hdl/rsf_sticky_byte.sv */
// one byte of sticky write-one-to-clear flags
`timescale 1ns/10ps
`default_nettype none
module rsf_sticky_byte
  import rsf_pkg::*;
#(
  parameter logic [7:0] IMPL_MASK = 8'hff
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] set_in,
  input wire logic clr_en,
  input wire logic [7:0] clr_data,
  output logic [7:0] flags
);
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  // set wins over a clear in the same cycle, so an event is never lost
  assign flags_next = ((flags_reg & ~(clr_en ? clr_data : 8'h00)) | set_in) & IMPL_MASK;
  assign flags = flags_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      flags_reg <= RSF_RESET_VAL;
    end else begin
      flags_reg <= flags_next;
    end
  end
endmodule // rsf_sticky_byte
`default_nettype wire

/* verification/rsf_host_model.sv */
// host side model: turns bench requests into one-cycle register strobes
`timescale 1ns/10ps
`default_nettype none
module rsf_host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] reg_addr = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_wdata = 8'h00
);
  // an idle bus toggles so a stale value never passes for a request
  always @(negedge clk) begin
    reg_rd <= go && !wr;
    reg_wr <= go && wr;
    reg_addr <= go ? addr : ~reg_addr;
    reg_wdata <= go ? wdata : ~reg_wdata;
  end
endmodule // rsf_host_model
`default_nettype wire

/* verification/rsf_regs_sva.sv */
// port checks for the rail status bank
`timescale 1ns/10ps
`default_nettype none
module rsf_regs_sva
  import rsf_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic [7:0] fault_mask_a,
  input wire logic [7:0] fault_mask_b,
  input wire logic shutdown_req
);
  logic mapped;
  assign mapped = reg_addr inside {RSF_ADDR_GOOD_B, RSF_ADDR_FAULT_A,
    RSF_ADDR_FAULT_B, RSF_ADDR_HOT};
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property resv_p(logic [7:0] a, logic [7:0] m);
    reg_rd && reg_addr == a |=> (reg_rdata & ~m) == 8'h00;
  endproperty
  a_hit_mapped: assert property ((reg_rd || reg_wr) && mapped |=> reg_hit)
    else $error("no hit");
  a_miss_quiet: assert property ((reg_rd || reg_wr) && !mapped |=> !reg_hit)
    else $error("unmapped hit");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("stray data");
  a_good_resv: assert property (resv_p(RSF_ADDR_GOOD_B, RSF_MASK_GOOD_B))
    else $error("reserved bit set");
  a_fa_resv: assert property (resv_p(RSF_ADDR_FAULT_A, RSF_MASK_FAULT_A))
    else $error("reserved bit set");
  a_fb_resv: assert property (resv_p(RSF_ADDR_FAULT_B, RSF_MASK_FAULT_B))
    else $error("reserved bit set");
  a_hot_resv: assert property (resv_p(RSF_ADDR_HOT, RSF_MASK_HOT))
    else $error("reserved bit set");
  a_reset_clean: assert property ($fell(srst) |-> !reg_hit && !shutdown_req)
    else $error("dirty after reset");
  a_mask_quiet: assert property ((fault_mask_a == 8'hff && fault_mask_b == 8'hff) [*3]
    |=> !shutdown_req) else $error("masked shutdown");
  c_hot: cover property (reg_rd && reg_addr == RSF_ADDR_HOT ##1 reg_rdata != 8'h00);
  c_shut: cover property ($rose(shutdown_req));
  c_clear: cover property (reg_wr && reg_addr == RSF_ADDR_FAULT_A);
endmodule // rsf_regs_sva
bind rsf_rail_status_regs rsf_regs_sva i_sva (.clk(clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .fault_mask_a(fault_mask_a), .fault_mask_b(fault_mask_b), .shutdown_req(shutdown_req));
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the rail status register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb;
  import rsf_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [18:0] p = 19'h00000;
  logic [7:0] ma = 8'hff;
  logic [7:0] mb = 8'hff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic reg_wr, reg_rd, reg_hit, shut;
  int n_errors = 0;
  int comparisons = 0;
  // pins: good 18:15, aux two 14, step-down 13:8, fault b 7:5, hot 4:0
  localparam logic [34:0] ROWS [15] = '{{19'h40000, 8'hb1, 8'h20}, {19'h20000, 8'hb1, 8'h10},
    {19'h10000, 8'hb1, 8'h08}, {19'h08000, 8'hb1, 8'h01}, {19'h04000, 8'hb2, 8'h80},
    {19'h00100, 8'hb2, 8'h01}, {19'h02000, 8'hb2, 8'h20}, {19'h00080, 8'hb3, 8'h10},
    {19'h00040, 8'hb3, 8'h08}, {19'h00020, 8'hb3, 8'h01}, {19'h00010, 8'hb5, 8'h10},
    {19'h00008, 8'hb5, 8'h08}, {19'h00004, 8'hb5, 8'h04}, {19'h00002, 8'hb5, 8'h02},
    {19'h00001, 8'hb5, 8'h01}};
  localparam logic [7:0] ADS [4] = '{8'hb1, 8'hb2, 8'hb3, 8'hb5};
  rsf_host_model i_host (.clk(clk), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  rsf_rail_status_regs i_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .five_volt_linear_good(p[18]), .aux_linear_one_good(p[17]),
    .termination_reg_good(p[16]), .aux_linear_three_good(p[15]),
    .aux_linear_two_fault(p[14]), .step_down_fault(p[13:8]), .aux_linear_one_fault(p[7]),
    .termination_reg_fault(p[6]), .aux_linear_three_fault(p[5]), .sensor_hot(p[4:0]),
    .fault_mask_a(ma), .fault_mask_b(mb), .shutdown_req(shut));
  initial forever #5 clk = ~clk;
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(negedge clk);
    go <= 1'b0;
    @(negedge clk);
    q = reg_rdata;
    `CHK(reg_hit, a inside {ADS})
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask
  task automatic end_sim;
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    srst <= 1'b0;
    foreach (ROWS[i]) begin
      p <= ROWS[i][34:16];
      repeat (5) @(negedge clk);
      rd(ROWS[i][15:8], ROWS[i][7:0]);
      p <= 19'h00000;
      repeat (5) @(negedge clk);
      rd(ROWS[i][15:8], ROWS[i][15:8] == RSF_ADDR_GOOD_B ? 8'h00 : ROWS[i][7:0]);
      foreach (ADS[j]) acc(1'b1, ADS[j], 8'hff);
    end
    p <= 19'h00300;
    repeat (5) @(negedge clk);
    p <= 19'h00000;
    acc(1'b1, RSF_ADDR_FAULT_A, 8'h01);
    rd(RSF_ADDR_FAULT_A, 8'h02);
    p <= 19'h00001;
    repeat (5) @(negedge clk);
    acc(1'b1, RSF_ADDR_HOT, 8'h01);
    rd(RSF_ADDR_HOT, 8'h01);
    p <= 19'h00000;
    repeat (5) @(negedge clk);
    acc(1'b1, RSF_ADDR_HOT, 8'h01);
    rd(RSF_ADDR_HOT, 8'h00);
    p <= 19'h78000;
    repeat (5) @(negedge clk);
    acc(1'b1, RSF_ADDR_GOOD_B, 8'hff);
    rd(RSF_ADDR_GOOD_B, 8'h39);
    rd(8'hb4, 8'h00);
    p <= 19'h00100;
    repeat (5) @(negedge clk);
    `CHK(shut, 1'b0)
    ma <= 8'hfe;
    repeat (5) @(negedge clk);
    `CHK(shut, 1'b1)
    ma <= 8'hff;
    p <= 19'h00040;
    repeat (5) @(negedge clk);
    `CHK(shut, 1'b0)
    mb <= 8'hf7;
    repeat (5) @(negedge clk);
    `CHK(shut, 1'b1)
    p <= 19'h00000;
    srst <= 1'b1;
    repeat (2) @(negedge clk);
    srst <= 1'b0;
    foreach (ADS[k]) rd(ADS[k], 8'h00);
    end_sim();
  end
endmodule // tb
`default_nettype wire
